// *** rtl/csa_top.sv ***
// apply engine top: ahb-lite registers, staged and active sets, apply procedures
`timescale 1ns/1ps
module csa_top #(
  parameter int unsigned NLANE = 8,
  parameter int unsigned APP_COUNT = 4,
  parameter bit HOT_SUPPORT = 1'b1,
  parameter bit STEP_ONLY = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // commissioned lane hardware settings
  output logic [NLANE*csa_pkg::CFG_W-1:0] hw_lane_cfg
);
  localparam int unsigned W = csa_pkg::CFG_W;

  csa_pkg::csa_eng_e eng_reg;
  logic [W-1:0] staged_reg [NLANE];
  logic [W-1:0] active_reg [NLANE];
  logic [3:0] result_reg [NLANE];
  logic [31:0] pctl_reg;
  logic [NLANE-1:0] exec_mask_reg;
  logic [NLANE-1:0] ok_reg;
  logic [NLANE-1:0] reinit_pls_reg;
  logic [NLANE-1:0] hot_pls_reg;
  logic hot_reg;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] rd_next;
  logic ahb_go;
  logic trig_wr;
  logic trig_fire;
  logic [NLANE-1:0] wmask;
  logic [NLANE-1:0] lane_ok;
  logic [NLANE-1:0] st_ok;
  logic [NLANE-1:0] si_only;
  logic [NLANE-1:0] path_ok;
  logic [NLANE-1:0] lane_busy;
  logic [NLANE-1:0] lane_run;
  csa_pkg::csa_path_e lane_state [NLANE];

  // byte lanes are not decoded: only whole-word transfers are supported
  assign ahb_go = hsel && hready && htrans[1];
  assign wmask = hwdata[NLANE-1:0];
  assign trig_wr = wr_pend_reg && (wr_addr_reg == csa_pkg::OFS_DPI_APPLY ||
                   wr_addr_reg == csa_pkg::OFS_HOT_APPLY);
  assign trig_fire = trig_wr && (wmask != '0);

  function automatic logic [3:0] state_code(csa_pkg::csa_path_e s);
    logic [3:0] c;
    c = csa_pkg::PSC_DEACT;
    unique case (s)
      csa_pkg::PS_DEACT: c = csa_pkg::PSC_DEACT;
      csa_pkg::PS_INIT: c = csa_pkg::PSC_INIT;
      csa_pkg::PS_INITD: c = csa_pkg::PSC_INITD;
      csa_pkg::PS_TXON: c = csa_pkg::PSC_TXON;
      csa_pkg::PS_ACT: c = csa_pkg::PSC_ACT;
      csa_pkg::PS_TXOFF: c = csa_pkg::PSC_TXOFF;
      csa_pkg::PS_DEINIT: c = csa_pkg::PSC_DEINIT;
      default: c = csa_pkg::PSC_DEACT;
    endcase
    return c;
  endfunction

  // each lane defaults to its own single-lane path
  function automatic logic [W-1:0] def_cfg(int i);
    logic [W-1:0] v;
    v = '0;
    v[csa_pkg::APPLICATION_SELECTOR_LSB +: 4] = csa_pkg::DEF_APPLICATION_SELECTOR;
    v[csa_pkg::DPID_LSB +: 3] = 3'(i);
    return v;
  endfunction

  // per-lane path state machines
  for (genvar g = 0; g < NLANE; g++)
  begin : g_lane
    csa_lane_if lif();
    csa_lane u_lane (
      .hclk(hclk),
      .hresetn(hresetn),
      .lif(lif)
    );
    assign lif.init_en = pctl_reg[g];
    assign lif.tx_en = pctl_reg[NLANE + g];
    assign lif.unused = (active_reg[g][csa_pkg::APPLICATION_SELECTOR_LSB +: 4] == csa_pkg::APPLICATION_SELECTOR_UNUSED);
    assign lif.reinit = reinit_pls_reg[g];
    assign lif.hot = hot_pls_reg[g];
    assign lif.active_cfg = active_reg[g];
    assign lane_busy[g] = lif.busy;
    assign lane_state[g] = lif.state;
    assign hw_lane_cfg[g*W +: W] = lif.hw_cfg;
    assign lane_run[g] = (lif.state == csa_pkg::PS_INITD) || (lif.state == csa_pkg::PS_ACT);
  end

  // read data is captured in the address phase so hrdata comes from a flop
  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (haddr[11:0])
      csa_pkg::OFS_ADVERT: rd_next = {30'h0, STEP_ONLY, HOT_SUPPORT};
      csa_pkg::OFS_STATUS: rd_next = {30'h0, eng_reg != csa_pkg::ENG_IDLE,
                                      eng_reg != csa_pkg::ENG_MGMT};
      csa_pkg::OFS_PCTL: rd_next = pctl_reg;
      default: rd_next = 32'h0000_0000;
    endcase
    for (int i = 0; i < NLANE; i++)
    begin
      if (haddr[11:0] == csa_pkg::OFS_PSTATE) rd_next[4*i +: 4] = state_code(lane_state[i]);
      if (haddr[11:0] == csa_pkg::OFS_RESULT) rd_next[4*i +: 4] = result_reg[i];
      if (haddr[11:0] == csa_pkg::OFS_STAGED + 12'(4*i)) rd_next = {16'h0, staged_reg[i]};
      if (haddr[11:0] == csa_pkg::OFS_ACTIVE + 12'(4*i)) rd_next = {16'h0, active_reg[i]};
    end
  end

  // bus slave: zero wait states, always okay, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= ahb_go && hwrite;
      if (ahb_go) wr_addr_reg <= haddr[11:0];
      if (ahb_go && !hwrite) hrdata <= rd_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // host path controls: init enable in low lanes, tx enable above
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) pctl_reg <= csa_pkg::PCTL_RST;
    else if (wr_pend_reg && wr_addr_reg == csa_pkg::OFS_PCTL) pctl_reg <= hwdata;
  end

  // staged set: host definition writes, defaults during management init
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NLANE; i++) staged_reg[i] <= '0;
    end
    else if (eng_reg == csa_pkg::ENG_MGMT)
    begin
      for (int i = 0; i < NLANE; i++) staged_reg[i] <= def_cfg(i);
    end
    else
    begin
      for (int i = 0; i < NLANE; i++)
        if (wr_pend_reg && wr_addr_reg == csa_pkg::OFS_STAGED + 12'(4*i))
          staged_reg[i] <= hwdata[W-1:0];
    end
  end

  // validation of the staged settings per path
  always_comb
  begin
    logic [3:0] app;
    logic [2:0] dp;
    app = 4'h0;
    dp = 3'h0;
    lane_ok = '0;
    st_ok = '0;
    si_only = '0;
    path_ok = '0;
    for (int i = 0; i < NLANE; i++)
    begin
      app = staged_reg[i][csa_pkg::APPLICATION_SELECTOR_LSB +: 4];
      dp = staged_reg[i][csa_pkg::DPID_LSB +: 3];
      lane_ok[i] = (app == csa_pkg::APPLICATION_SELECTOR_UNUSED) ||
                   (app <= 4'(APP_COUNT) && int'(dp) <= i && int'(dp) < NLANE &&
                    staged_reg[dp][csa_pkg::APPLICATION_SELECTOR_LSB +: 4] == app &&
                    staged_reg[dp][csa_pkg::DPID_LSB +: 3] == dp);
      si_only[i] = (staged_reg[i][csa_pkg::EC_BIT:0] == active_reg[i][csa_pkg::EC_BIT:0]);
      // transient states are refused outright rather than left undetermined
      unique case (lane_state[i])
        csa_pkg::PS_DEACT: st_ok[i] = 1'b1;
        csa_pkg::PS_INITD, csa_pkg::PS_ACT: st_ok[i] = !STEP_ONLY;
        default: st_ok[i] = 1'b0;
      endcase
      if (hot_reg && !HOT_SUPPORT) st_ok[i] = 1'b0;
    end
    for (int i = 0; i < NLANE; i++)
    begin
      path_ok[i] = lane_ok[i] && st_ok[i];
      for (int j = 0; j < NLANE; j++)
        if (j != i && staged_reg[i][3:0] != csa_pkg::APPLICATION_SELECTOR_UNUSED &&
            staged_reg[j][3:0] != csa_pkg::APPLICATION_SELECTOR_UNUSED &&
            staged_reg[j][6:4] == staged_reg[i][6:4])
          path_ok[i] = path_ok[i] && (exec_mask_reg[j] ? (lane_ok[j] && st_ok[j])
                       : (hot_reg && si_only[i] && lane_run[i]));
    end
  end

  // procedure sequencer: one trigger is processed at a time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eng_reg <= csa_pkg::ENG_MGMT;
      exec_mask_reg <= '0;
      ok_reg <= '0;
      hot_reg <= 1'b0;
    end
    else
    begin
      unique case (eng_reg)
        csa_pkg::ENG_MGMT: eng_reg <= csa_pkg::ENG_IDLE;
        csa_pkg::ENG_IDLE:
          if (trig_fire)
          begin
            eng_reg <= csa_pkg::ENG_VALID;
            exec_mask_reg <= wmask;
            hot_reg <= (wr_addr_reg == csa_pkg::OFS_HOT_APPLY);
          end
        csa_pkg::ENG_VALID:
        begin
          ok_reg <= path_ok;
          eng_reg <= csa_pkg::ENG_COPY;
        end
        csa_pkg::ENG_COPY: eng_reg <= csa_pkg::ENG_WAIT;
        csa_pkg::ENG_WAIT:
          if (((lane_busy & exec_mask_reg) == '0) && ((reinit_pls_reg | hot_pls_reg) == '0))
            eng_reg <= csa_pkg::ENG_DONE;
        csa_pkg::ENG_DONE:
        begin
          eng_reg <= csa_pkg::ENG_IDLE;
          exec_mask_reg <= '0;
        end
      endcase
    end
  end

  // active set: copy only paths that passed validation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NLANE; i++) active_reg[i] <= '0;
    end
    else if (eng_reg == csa_pkg::ENG_MGMT)
    begin
      for (int i = 0; i < NLANE; i++) active_reg[i] <= def_cfg(i);
    end
    else if (eng_reg == csa_pkg::ENG_COPY)
    begin
      for (int i = 0; i < NLANE; i++)
        if (exec_mask_reg[i] && ok_reg[i]) active_reg[i] <= staged_reg[i];
    end
  end

  // commissioning kicks only for running paths; deactivated lanes stay idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reinit_pls_reg <= '0;
      hot_pls_reg <= '0;
    end
    else
    begin
      reinit_pls_reg <= '0;
      hot_pls_reg <= '0;
      if (eng_reg == csa_pkg::ENG_COPY)
      begin
        for (int i = 0; i < NLANE; i++)
          if (exec_mask_reg[i] && ok_reg[i] && lane_run[i])
          begin
            if (hot_reg) hot_pls_reg[i] <= 1'b1;
            else reinit_pls_reg[i] <= 1'b1;
          end
      end
    end
  end

  // lane config result: executing on acceptance, verdict at the end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NLANE; i++) result_reg[i] <= csa_pkg::RES_UNDEF;
    end
    else
    begin
      for (int i = 0; i < NLANE; i++)
      begin
        if (eng_reg == csa_pkg::ENG_IDLE && trig_fire && wmask[i])
          result_reg[i] <= csa_pkg::RES_EXECUTING;
        else if (eng_reg == csa_pkg::ENG_DONE && exec_mask_reg[i])
          result_reg[i] <= ok_reg[i] ? csa_pkg::RES_SUCCESS : csa_pkg::RES_REJECTED;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence accept_s;
    eng_reg == csa_pkg::ENG_IDLE && trig_fire;
  endsequence
  sequence check_copy_s;
    eng_reg == csa_pkg::ENG_VALID ##1 eng_reg == csa_pkg::ENG_COPY;
  endsequence

  valid_then_copy_a: assert property (accept_s |=> check_copy_s)
    else $error("copy not preceded by validation");
  exec_flag_a: assert property (eng_reg == csa_pkg::ENG_IDLE && trig_fire && wmask[0]
    |=> result_reg[0] == csa_pkg::RES_EXECUTING)
    else $error("accepted lane not marked executing");
  zero_mask_a: assert property (eng_reg == csa_pkg::ENG_IDLE && trig_wr && wmask == '0
    |=> eng_reg == csa_pkg::ENG_IDLE)
    else $error("empty mask started a procedure");
  busy_ignore_a: assert property (eng_reg == csa_pkg::ENG_WAIT && trig_wr
    |=> $stable(exec_mask_reg))
    else $error("trigger accepted while busy");
  reject_keep_a: assert property (eng_reg == csa_pkg::ENG_COPY && !ok_reg[0]
    |=> $stable(active_reg[0]))
    else $error("rejected lane was copied");
  result_code_a: assert property (eng_reg == csa_pkg::ENG_DONE && exec_mask_reg[0]
    |=> result_reg[0] == ($past(ok_reg[0]) ? csa_pkg::RES_SUCCESS : csa_pkg::RES_REJECTED))
    else $error("wrong lane result code");
  transient_rej_a: assert property (eng_reg == csa_pkg::ENG_VALID && exec_mask_reg[0]
    && lane_state[0] == csa_pkg::PS_INIT |=> ##3 result_reg[0] == csa_pkg::RES_REJECTED)
    else $error("transient lane not rejected");
endmodule

// *** rtl/csa_pkg.sv ***
// shared constants and types for the control set apply engine
package csa_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CFG_W = 16;
  // register byte offsets
  localparam logic [11:0] OFS_ADVERT = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DPI_APPLY = 12'h008;
  localparam logic [11:0] OFS_HOT_APPLY = 12'h00c;
  localparam logic [11:0] OFS_PCTL = 12'h010;
  localparam logic [11:0] OFS_PSTATE = 12'h014;
  localparam logic [11:0] OFS_RESULT = 12'h018;
  localparam logic [11:0] OFS_STAGED = 12'h040;
  localparam logic [11:0] OFS_ACTIVE = 12'h080;
  // lane configuration word layout
  localparam int unsigned APPLICATION_SELECTOR_LSB = 0;
  localparam int unsigned DPID_LSB = 4;
  localparam int unsigned EC_BIT = 7;
  localparam int unsigned SI_LSB = 8;
  localparam logic [3:0] APPLICATION_SELECTOR_UNUSED = 4'h0;
  localparam logic [3:0] DEF_APPLICATION_SELECTOR = 4'h1;
  localparam logic [31:0] PCTL_RST = 32'h0000_0000;
  // lane config result codes
  localparam logic [3:0] RES_UNDEF = 4'h0;
  localparam logic [3:0] RES_SUCCESS = 4'h1;
  localparam logic [3:0] RES_REJECTED = 4'h2;
  localparam logic [3:0] RES_EXECUTING = 4'hc;
  // reported path state codes
  localparam logic [3:0] PSC_DEACT = 4'h1;
  localparam logic [3:0] PSC_INIT = 4'h2;
  localparam logic [3:0] PSC_DEINIT = 4'h3;
  localparam logic [3:0] PSC_ACT = 4'h4;
  localparam logic [3:0] PSC_TXON = 4'h5;
  localparam logic [3:0] PSC_TXOFF = 4'h6;
  localparam logic [3:0] PSC_INITD = 4'h7;
  // state durations in ns, and cycles rounded up
  localparam int unsigned INIT_NS = 1000;
  localparam int unsigned DEINIT_NS = 500;
  localparam int unsigned TXON_NS = 500;
  localparam int unsigned TXOFF_NS = 500;
  localparam int unsigned HOT_NS = 250;
  localparam logic [11:0] INIT_CYC = 12'((INIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] DEINIT_CYC = 12'((DEINIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] TXON_CYC = 12'((TXON_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] TXOFF_CYC = 12'((TXOFF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] HOT_CYC = 12'((HOT_NS * CLK_MHZ + 999) / 1000);
  typedef enum logic [6:0] {
    PS_DEACT = 7'h01, PS_INIT = 7'h02, PS_INITD = 7'h04, PS_TXON = 7'h08,
    PS_ACT = 7'h10, PS_TXOFF = 7'h20, PS_DEINIT = 7'h40
  } csa_path_e;
  typedef enum logic [5:0] {
    ENG_MGMT = 6'h01, ENG_IDLE = 6'h02, ENG_VALID = 6'h04,
    ENG_COPY = 6'h08, ENG_WAIT = 6'h10, ENG_DONE = 6'h20
  } csa_eng_e;
endpackage

// *** rtl/csa_lane_if.sv ***
// per-lane link between the apply engine and one path state machine
`timescale 1ns/1ps
interface csa_lane_if;
  logic init_en;
  logic tx_en;
  logic unused;
  logic reinit;
  logic hot;
  logic busy;
  logic [csa_pkg::CFG_W-1:0] active_cfg;
  logic [csa_pkg::CFG_W-1:0] hw_cfg;
  csa_pkg::csa_path_e state;
  modport eng (output init_en, tx_en, unused, reinit, hot, active_cfg,
               input busy, hw_cfg, state);
  modport lane (input init_en, tx_en, unused, reinit, hot, active_cfg,
                output busy, hw_cfg, state);
endinterface

// *** rtl/csa_lane.sv ***
// per-lane path state machine and realization of the active settings
`timescale 1ns/1ps
module csa_lane (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // engine side
  csa_lane_if.lane lif
);
  csa_pkg::csa_path_e st_reg;
  csa_pkg::csa_path_e st_next;
  logic [11:0] tmr_reg;
  logic [11:0] tmr_next;
  logic [11:0] hot_reg;
  logic [csa_pkg::CFG_W-1:0] hw_reg;
  logic reinit_reg;
  logic seq_reg;
  logic tmr_done;
  logic stable;

  assign tmr_done = (tmr_reg == 12'h000);
  assign stable = (st_next == st_reg) && (st_reg == csa_pkg::PS_DEACT ||
                  st_reg == csa_pkg::PS_INITD || st_reg == csa_pkg::PS_ACT);
  assign lif.state = st_reg;
  assign lif.hw_cfg = hw_reg;
  assign lif.busy = seq_reg || (hot_reg != 12'h000);

  // pending reinit forces the cycle down; host enables bring it back up
  always_comb
  begin
    st_next = st_reg;
    tmr_next = 12'h000;
    unique case (st_reg)
      csa_pkg::PS_DEACT: if (lif.init_en && !lif.unused) st_next = csa_pkg::PS_INIT;
      csa_pkg::PS_INIT: if (tmr_done) st_next = csa_pkg::PS_INITD;
      csa_pkg::PS_INITD:
        if (reinit_reg || !lif.init_en) st_next = csa_pkg::PS_DEINIT;
        else if (lif.tx_en) st_next = csa_pkg::PS_TXON;
      csa_pkg::PS_TXON: if (tmr_done) st_next = csa_pkg::PS_ACT;
      csa_pkg::PS_ACT:
        if (reinit_reg || !lif.tx_en || !lif.init_en) st_next = csa_pkg::PS_TXOFF;
      csa_pkg::PS_TXOFF: if (tmr_done) st_next = csa_pkg::PS_INITD;
      csa_pkg::PS_DEINIT: if (tmr_done) st_next = csa_pkg::PS_DEACT;
    endcase
    if (st_next == csa_pkg::PS_INIT) tmr_next = csa_pkg::INIT_CYC;
    if (st_next == csa_pkg::PS_DEINIT) tmr_next = csa_pkg::DEINIT_CYC;
    if (st_next == csa_pkg::PS_TXON) tmr_next = csa_pkg::TXON_CYC;
    if (st_next == csa_pkg::PS_TXOFF) tmr_next = csa_pkg::TXOFF_CYC;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) st_reg <= csa_pkg::PS_DEACT;
    else st_reg <= st_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) tmr_reg <= 12'h000;
    else if (st_next != st_reg) tmr_reg <= tmr_next;
    else if (!tmr_done) tmr_reg <= tmr_reg - 12'h001;
  end

  // reinit request clears once the path has been fully deactivated
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reinit_reg <= 1'b0;
      seq_reg <= 1'b0;
    end
    else
    begin
      if (lif.reinit) reinit_reg <= 1'b1;
      else if (st_reg == csa_pkg::PS_DEACT) reinit_reg <= 1'b0;
      if (lif.reinit) seq_reg <= 1'b1;
      else if (!reinit_reg && stable) seq_reg <= 1'b0;
    end
  end

  // hot procedure runs beside the state machine without touching it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) hot_reg <= 12'h000;
    else if (lif.hot) hot_reg <= csa_pkg::HOT_CYC;
    else if (hot_reg != 12'h000) hot_reg <= hot_reg - 12'h001;
  end

  // best effort: settings pass verbatim to the lane hardware
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) hw_reg <= '0;
    else if (st_reg == csa_pkg::PS_INIT && tmr_done) hw_reg <= lif.active_cfg;
    else if (hot_reg == 12'h001) hw_reg <= lif.active_cfg;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  unused_lane_a: assert property (lif.unused && st_reg == csa_pkg::PS_DEACT
    |=> st_reg == csa_pkg::PS_DEACT)
    else $error("unused lane left deactivated");
  init_commit_a: assert property (st_reg == csa_pkg::PS_INIT && tmr_done
    |=> st_reg == csa_pkg::PS_INITD && lif.hw_cfg == $past(lif.active_cfg))
    else $error("init did not commit active settings");
  hot_stays_a: assert property (lif.hot && stable
    |=> st_reg == $past(st_reg) && lif.busy)
    else $error("hot apply moved the path state");
  reinit_down_a: assert property (lif.reinit && st_reg == csa_pkg::PS_ACT
    |-> ##[1:3] st_reg == csa_pkg::PS_TXOFF)
    else $error("reinit did not leave activated");
endmodule

// *** dv/csa_host.sv ***
// ahb-lite host model issuing single word transfers
`timescale 1ns/1ps
module csa_host (
  // clock
  input wire logic hclk,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // released lines flip so a stale value never reads as a match
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the apply engine
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [127:0] hw;
  logic [31:0] q;
  int failures = 0;
  int n_tests = 0;
  always #12.5 hclk = ~hclk;
  csa_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  csa_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hw_lane_cfg(hw));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0, d);
  endtask
  // poll until no procedure runs; the watchdog bounds a hang
  task automatic idle();
    q = 32'h2;
    while (q[1] !== 1'b0) rd(csa_pkg::OFS_STATUS, q);
  endtask
  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // poll the path state of lanes 0 and 1; gives up after 200 reads
  task automatic wait_state(input logic [7:0] s);
    int n;
    n = 0;
    q = 32'h0;
    while (q[7:0] !== s && n < 200)
    begin
      rd(csa_pkg::OFS_PSTATE, q);
      n++;
    end
  endtask
  task automatic t_init();
    rd(csa_pkg::OFS_ADVERT, q);
    chk(q & 32'h3, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    rd(csa_pkg::OFS_ACTIVE + 12'hc, q);
    chk(q & 32'hffff, 32'h0031);
    rd(csa_pkg::OFS_STAGED, q);
    chk(q & 32'hffff, 32'h0001);
    rd(12'h020, q);
    chk(q, 32'h0);
    rd(csa_pkg::OFS_PSTATE, q);
    chk(q, 32'h1111_1111);
  endtask
  // second trigger lands while the first still runs and must leave lane 2 alone
  task automatic t_provision();
    wr(csa_pkg::OFS_STAGED, 32'h5502);
    wr(csa_pkg::OFS_STAGED + 12'h4, 32'h5502);
    wr(csa_pkg::OFS_DPI_APPLY, 32'h13);
    wr(csa_pkg::OFS_DPI_APPLY, 32'h04);
    idle();
    rd(csa_pkg::OFS_RESULT, q);
    chk(q, 32'h0001_0011);
    rd(csa_pkg::OFS_ACTIVE + 12'h4, q);
    chk(q & 32'hffff, 32'h5502);
    chk(hw[31:0], 32'h0);
  endtask
  task automatic t_reject();
    wr(csa_pkg::OFS_STAGED + 12'h8, 32'h002f);
    wr(csa_pkg::OFS_STAGED + 12'hc, 32'h0000);
    wr(csa_pkg::OFS_DPI_APPLY, 32'h0c);
    idle();
    rd(csa_pkg::OFS_RESULT, q);
    chk(q & 32'hff00, 32'h1200);
    rd(csa_pkg::OFS_ACTIVE + 12'h8, q);
    chk(q & 32'hffff, 32'h0021);
    rd(csa_pkg::OFS_ACTIVE + 12'hc, q);
    chk(q & 32'hffff, 32'h0);
    wr(csa_pkg::OFS_DPI_APPLY, 32'h0);
    rd(csa_pkg::OFS_STATUS, q);
    chk(q & 32'h3, 32'h1);
  endtask
  task automatic t_commission();
    wr(csa_pkg::OFS_PCTL, 32'h3);
    wr(csa_pkg::OFS_HOT_APPLY, 32'h03);
    idle();
    rd(csa_pkg::OFS_RESULT, q);
    chk(q & 32'hff, 32'h22);
    wait_state(8'h77);
    chk(q & 32'hff, 32'h77);
    chk(hw[31:0], 32'h5502_5502);
  endtask
  task automatic t_hot();
    wr(csa_pkg::OFS_STAGED, 32'h6602);
    wr(csa_pkg::OFS_HOT_APPLY, 32'h01);
    idle();
    rd(csa_pkg::OFS_RESULT, q);
    chk(q & 32'hff, 32'h21);
    rd(csa_pkg::OFS_PSTATE, q);
    chk(q & 32'hff, 32'h77);
    chk(hw[31:0], 32'h5502_6602);
  endtask
  // reconfigure from activated: the automatic cycle must come back to activated
  task automatic t_reconfig();
    wr(csa_pkg::OFS_PCTL, 32'h303);
    wait_state(8'h44);
    chk(q & 32'hff, 32'h44);
    wr(csa_pkg::OFS_STAGED, 32'h7703);
    wr(csa_pkg::OFS_STAGED + 12'h4, 32'h7703);
    wr(csa_pkg::OFS_DPI_APPLY, 32'h03);
    rd(csa_pkg::OFS_RESULT, q);
    chk(q & 32'hff, 32'hcc);
    idle();
    rd(csa_pkg::OFS_RESULT, q);
    chk(q & 32'hff, 32'h11);
    rd(csa_pkg::OFS_PSTATE, q);
    chk(q & 32'hff, 32'h44);
    chk(hw[31:0], 32'h7703_7703);
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_init();
    t_provision();
    t_reject();
    t_commission();
    t_hot();
    t_reconfig();
    print_verdict();
  end
  initial
  begin
    #1000000;
    failures++;
    print_verdict();
  end
endmodule
